// [core/slx_pkg.sv]
/*
  package for the serial lane crossbar: register offsets, field layout,
  reset values and the packed carriers shared by the design.
  assumes an apb slave with 32-bit data, one aligned word per register.
*/
package slx_pkg;
  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int LANES = 8;
  localparam int LANE_W = 32; // parallel word per lane
  localparam int SEL_W = 3;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------------
  // register indices as printed; byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_ROUTE_ZERO_ONE = 12'h308;
  localparam logic [ADDR_W-1:0] IDX_ROUTE_TWO_THREE = 12'h309;
  localparam logic [ADDR_W-1:0] IDX_ROUTE_FOUR_FIVE = 12'h30A;
  localparam logic [ADDR_W-1:0] IDX_ROUTE_SIX_SEVEN = 12'h30B;
  localparam int IDX_SHIFT = 2;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int HI_LSB = 3; // upper select at [5:3]
  localparam int LO_LSB = 0; // lower select at [2:0]
  localparam int USED_W = 6; // bits 7:6 reserved

  // ----------------------------------------------------------------------
  // reset selects: identity routing
  // ----------------------------------------------------------------------
  localparam logic [SEL_W-1:0] RST_SEL0 = 3'h0;
  localparam logic [SEL_W-1:0] RST_SEL1 = 3'h1;
  localparam logic [SEL_W-1:0] RST_SEL2 = 3'h2;
  localparam logic [SEL_W-1:0] RST_SEL3 = 3'h3;
  localparam logic [SEL_W-1:0] RST_SEL4 = 3'h4;
  localparam logic [SEL_W-1:0] RST_SEL5 = 3'h5;
  localparam logic [SEL_W-1:0] RST_SEL6 = 3'h6;
  localparam logic [SEL_W-1:0] RST_SEL7 = 3'h7;

  // apb answer to an unmapped address
  localparam logic SLVERR_UNMAPPED = 1'b1;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [LANE_W-1:0] lane7;
    logic [LANE_W-1:0] lane6;
    logic [LANE_W-1:0] lane5;
    logic [LANE_W-1:0] lane4;
    logic [LANE_W-1:0] lane3;
    logic [LANE_W-1:0] lane2;
    logic [LANE_W-1:0] lane1;
    logic [LANE_W-1:0] lane0;
  } slx_lanes_t;

  typedef struct packed {
    logic [SEL_W-1:0] logical_seven_source;
    logic [SEL_W-1:0] logical_six_source;
    logic [SEL_W-1:0] logical_five_source;
    logic [SEL_W-1:0] logical_four_source;
    logic [SEL_W-1:0] logical_three_source;
    logic [SEL_W-1:0] logical_two_source;
    logic [SEL_W-1:0] logical_one_source;
    logic [SEL_W-1:0] logical_zero_source;
  } slx_sel_t;

  typedef enum logic [0:0] {
    SLX_IDLE = 1'b0,
    SLX_DONE = 1'b1
  } slx_state_t;
endpackage

// [core/slx_crossbar.sv]
/*
  serial lane crossbar: eight physical deserialized lane words are routed
  onto eight logical lanes by software-programmed 3-bit selects.
  assumes the physical words and the apb bus are synchronous to ref_clk;
  arst_n is released through a two-stage synchroniser inside this module.
*/
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module slx_crossbar (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire slx_pkg::slx_lanes_t phys_lanes,
  output slx_pkg::slx_lanes_t logical_lanes,
  output slx_pkg::slx_sel_t lane_selects
);
  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rst_meta_r; // first stage, read only by the second
  logic rst_n_r; // synchronised reset used everywhere else

  // release is delayed two edges so all flops leave reset together
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // pick physical lane n; a plain index, so every code maps somewhere
  function automatic logic [slx_pkg::LANE_W-1:0] pick_lane(
    input slx_pkg::slx_lanes_t lanes,
    input logic [slx_pkg::SEL_W-1:0] sel
  );
    logic [slx_pkg::LANES-1:0][slx_pkg::LANE_W-1:0] arr;
    arr = lanes;
    pick_lane = arr[sel];
  endfunction

  // pack two selects into a register image; bits 7:6 and up read zero
  function automatic logic [31:0] pack_pair(
    input logic [slx_pkg::SEL_W-1:0] hi,
    input logic [slx_pkg::SEL_W-1:0] lo
  );
    pack_pair = {26'h0000000, hi, lo};
  endfunction

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  slx_pkg::slx_state_t state_r; // access phase answered yet
  logic [11:0] reg_idx; // word index from byte address
  logic hit01, hit23, hit45, hit67, mapped;
  logic wr_en; // write takes effect on this edge
  logic [slx_pkg::SEL_W-1:0] sel_r [slx_pkg::LANES]; // select per logical lane

  assign reg_idx = paddr[13:slx_pkg::IDX_SHIFT];

  // address decoding kept as an if chain
  always_comb begin
    hit01 = 1'b0;
    hit23 = 1'b0;
    hit45 = 1'b0;
    hit67 = 1'b0;
    if (reg_idx == slx_pkg::IDX_ROUTE_ZERO_ONE) begin
      hit01 = 1'b1;
    end else if (reg_idx == slx_pkg::IDX_ROUTE_TWO_THREE) begin
      hit23 = 1'b1;
    end else if (reg_idx == slx_pkg::IDX_ROUTE_FOUR_FIVE) begin
      hit45 = 1'b1;
    end else if (reg_idx == slx_pkg::IDX_ROUTE_SIX_SEVEN) begin
      hit67 = 1'b1;
    end
  end
  assign mapped = hit01 | hit23 | hit45 | hit67;

  // zero wait states: ready in the first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped & slx_pkg::SLVERR_UNMAPPED;
  // only byte lane 0 carries register bits, so pstrb[0] gates writes
  assign wr_en = psel & penable & pwrite & mapped & pstrb[0];

  // state marker: kept for observing back-to-back access phases
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= slx_pkg::SLX_IDLE;
    end else begin
      case (state_r)
        slx_pkg::SLX_IDLE: begin
          if (psel && penable) begin
            state_r <= slx_pkg::SLX_DONE;
          end
        end
        default: begin
          state_r <= slx_pkg::SLX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // select registers
  // ----------------------------------------------------------------------
  // writes land at the access edge; bits 7:6 are never stored
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel_r[0] <= slx_pkg::RST_SEL0;
      sel_r[1] <= slx_pkg::RST_SEL1;
      sel_r[2] <= slx_pkg::RST_SEL2;
      sel_r[3] <= slx_pkg::RST_SEL3;
      sel_r[4] <= slx_pkg::RST_SEL4;
      sel_r[5] <= slx_pkg::RST_SEL5;
      sel_r[6] <= slx_pkg::RST_SEL6;
      sel_r[7] <= slx_pkg::RST_SEL7;
    end else if (wr_en) begin
      if (hit01) begin
        sel_r[1] <= pwdata[slx_pkg::HI_LSB +: slx_pkg::SEL_W];
        sel_r[0] <= pwdata[slx_pkg::LO_LSB +: slx_pkg::SEL_W];
      end else if (hit23) begin
        sel_r[3] <= pwdata[slx_pkg::HI_LSB +: slx_pkg::SEL_W];
        sel_r[2] <= pwdata[slx_pkg::LO_LSB +: slx_pkg::SEL_W];
      end else if (hit45) begin
        sel_r[5] <= pwdata[slx_pkg::HI_LSB +: slx_pkg::SEL_W];
        sel_r[4] <= pwdata[slx_pkg::LO_LSB +: slx_pkg::SEL_W];
      end else begin
        sel_r[7] <= pwdata[slx_pkg::HI_LSB +: slx_pkg::SEL_W];
        sel_r[6] <= pwdata[slx_pkg::LO_LSB +: slx_pkg::SEL_W];
      end
    end
  end

  // read data is combinational whenever psel is high on a read, setup phase included; zero elsewhere
  always_comb begin
    prdata = 32'h00000000;
    if (psel && !pwrite) begin
      if (hit01) begin
        prdata = pack_pair(sel_r[1], sel_r[0]);
      end else if (hit23) begin
        prdata = pack_pair(sel_r[3], sel_r[2]);
      end else if (hit45) begin
        prdata = pack_pair(sel_r[5], sel_r[4]);
      end else if (hit67) begin
        prdata = pack_pair(sel_r[7], sel_r[6]);
      end
    end
  end

  assign lane_selects = {sel_r[7], sel_r[6], sel_r[5], sel_r[4], sel_r[3], sel_r[2], sel_r[1], sel_r[0]};

  // ----------------------------------------------------------------------
  // crossbar datapath
  // ----------------------------------------------------------------------
  logic [slx_pkg::LANES-1:0][slx_pkg::LANE_W-1:0] out_nxt;

  // each logical lane takes the physical lane its select names
  always_comb begin
    for (int i = 0; i < slx_pkg::LANES; i++) begin
      out_nxt[i] = pick_lane(phys_lanes, sel_r[i]);
    end
  end

  // registered output: a select written at edge k steers data at edge k+1
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      logical_lanes <= '0;
    end else begin
      logical_lanes <= out_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [slx_pkg::LANES-1:0][slx_pkg::LANE_W-1:0] phys_arr;
  logic [slx_pkg::LANES-1:0][slx_pkg::LANE_W-1:0] out_arr;
  assign phys_arr = phys_lanes;
  assign out_arr = logical_lanes;

  // the first edge out of reset still shows the cleared word, so it is skipped;
  // a select write does not excuse the route, the old select steers that edge
  route_lane2_a: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
    $past(rst_n_r) |-> out_arr[2] == $past(phys_arr[sel_r[2]])) else $error("lane 2 misrouted");
  route_lane7_a: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
    $past(rst_n_r) |-> out_arr[7] == $past(phys_arr[sel_r[7]])) else $error("lane 7 misrouted");
  reset_two_a: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
    $rose(rst_n_r) || $past(!rst_n_r) |-> sel_r[2] == slx_pkg::RST_SEL2) else $error("lane 2 reset wrong");
  write_four_five_a: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
    wr_en && hit45 |=> sel_r[5] == $past(pwdata[5:3]) && sel_r[4] == $past(pwdata[2:0]))
    else $error("route four_five write lost");
  write_six_seven_a: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
    wr_en && hit67 |=> sel_r[7] == $past(pwdata[5:3]) && sel_r[6] == $past(pwdata[2:0]))
    else $error("route six_seven write lost");
  pick_five_a: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
    sel_r[4] == 3'h5 && !wr_en |=> out_arr[4] == $past(phys_arr[5])) else $error("value 5 not lane 5");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
    psel && !pwrite && mapped |-> prdata[31:6] == 26'h0000000) else $error("reserved bits not zero");
  next_clock_a: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
    wr_en && hit45 ##1 !wr_en |=> out_arr[5] == $past(phys_arr[sel_r[5]])) else $error("select late");
endmodule

// [verification/slx_lane_source.sv]
/*
  far-side model: the transmitter logic that feeds eight deserialized lane
  words. assumes the bench's ref_clk and arst_n.
*/
`timescale 1ns/10ps
module slx_lane_source (
  input wire logic ref_clk,
  input wire logic arst_n,
  output slx_pkg::slx_lanes_t phys_lanes
);
  logic [23:0] beat_r; // free-running beat count
  logic [255:0] words; // flat copy of the eight lane words

  // beat advances every cycle, so a stale or early word never matches
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      beat_r <= 24'h0;
    end else begin
      beat_r <= beat_r + 24'h1;
    end
  end

  // 160 plus the lane number in the top byte makes a wrong route visible
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      words[i*32 +: 32] = {8'(160 + i), beat_r};
    end
  end
  assign phys_lanes = words;
endmodule

// [verification/slx_crossbar_tb.sv]
/*
  self-checking bench for the serial lane crossbar: apb master tasks,
  a model of the expected selects and a check of the routed words.
  assumes the far side is slx_lane_source and zero-wait apb answers.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module slx_crossbar_tb;
  logic ref_clk, arst_n, psel, penable, pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, err;
  slx_pkg::slx_lanes_t phys_lanes, logical_lanes;
  slx_pkg::slx_sel_t lane_selects;
  logic [2:0] exp_sel [8]; // selects the bench expects
  int n_mismatch = 0, num_checks = 0;

  slx_crossbar slx_crossbar_inst (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phys_lanes(phys_lanes), .logical_lanes(logical_lanes), .lane_selects(lane_selects));
  slx_lane_source slx_lane_source_inst (.ref_clk(ref_clk), .arst_n(arst_n), .phys_lanes(phys_lanes));

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer; byte address is four times the register index
  task automatic apb(input logic [11:0] idx, input logic wr, input logic [31:0] wd, input logic [3:0] st);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd; pstrb <= st;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++; // a hung slave ends the run
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // phys seen at one negedge is what the next edge samples
  task automatic chk_path();
    logic [255:0] snap;
    @(negedge ref_clk);
    snap = phys_lanes;
    @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      `CHK("lane select", exp_sel[i], lane_selects[i*3 +: 3])
      `CHK("logical lane", snap[exp_sel[i]*32 +: 32], logical_lanes[i*32 +: 32])
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk_path();
    for (int k = 0; k < 4; k++) begin
      apb(12'h308 + 12'(k), 1'b0, 32'h0, 4'h0);
      `CHK("reset value", {26'h0, 3'(2*k+1), 3'(2*k)}, rd)
      `CHK("mapped error", 1'b0, err)
    end
  endtask

  // every code on selects 2 and 4 to 7, three register writes with one idle cycle between transfers
  task automatic t_route();
    for (int v = 0; v < 8; v++) begin
      apb(12'h30A, 1'b1, {26'h0, 3'(v), 3'(7-v)}, 4'hF);
      apb(12'h30B, 1'b1, {26'h0, 3'(v+3), 3'(v+1)}, 4'hF);
      apb(12'h309, 1'b1, {26'h0, 3'h3, 3'(v)}, 4'hF);
      exp_sel[5] = 3'(v); exp_sel[4] = 3'(7-v);
      exp_sel[7] = 3'(v+3); exp_sel[6] = 3'(v+1); exp_sel[2] = 3'(v);
      chk_path();
      apb(12'h30A, 1'b0, 32'h0, 4'h0);
      `CHK("route four five", {26'h0, 3'(v), 3'(7-v)}, rd)
    end
  endtask

  // reserved bits, masked write, unmapped index
  task automatic t_reserved();
    apb(12'h30B, 1'b1, 32'hFFFFFFFF, 4'hF);
    apb(12'h30B, 1'b0, 32'h0, 4'h0);
    `CHK("reserved bits", 32'h0000003F, rd)
    apb(12'h30B, 1'b1, 32'h00000000, 4'h0);
    apb(12'h30B, 1'b0, 32'h0, 4'h0);
    `CHK("masked write", 32'h0000003F, rd)
    apb(12'h30C, 1'b0, 32'h0, 4'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    // an unmapped write must answer with an error and store nothing
    apb(12'h30C, 1'b1, 32'h00000000, 4'hF);
    `CHK("unmapped write error", 1'b1, err)
    exp_sel[6] = 3'h7; exp_sel[7] = 3'h7;
    chk_path();
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 14'h0; pwdata = 32'h0; pstrb = 4'h0;
    for (int i = 0; i < 8; i++) begin
      exp_sel[i] = 3'(i);
    end
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_route();
    t_reserved();
    finish_test();
  end
endmodule
